// ### hdl/cgp_pkg.sv
/*
  Shared constants and types for the clock gating and power state controller:
  register byte offsets, field positions, reset values, timing counts and the
  regulator state encoding. Assumes a 125 MHz system clock.
*/
package cgp_pkg;

  // Clock rate and derived cycle counts.
  localparam int CLK_PERIOD_NS = 8;
  localparam int STROBE_NS = 1000;
  localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int EXIT_CYC = 3;
  localparam int ENTRY_CYC = 3;

  // Structure sizes.
  localparam int NLEAF = 16;
  localparam int NASYNC = 2;
  localparam int NSYNC = 2;
  localparam int ASYNC_LEAF0 = 0;
  localparam int SYNC_LEAF0 = 2;

  // Register byte offsets.
  localparam logic [7:0] ADDR_LEAF_GATE = 8'h00;
  localparam logic [7:0] ADDR_SW_GATE = 8'h04;
  localparam logic [7:0] ADDR_HALT_CTRL = 8'h08;
  localparam logic [7:0] ADDR_VREG_CTRL = 8'h0c;
  localparam logic [7:0] ADDR_STATUS = 8'h10;

  // Field positions.
  localparam int HALT_CPU_BIT = 0;
  localparam int HALT_MEM_BIT = 1;
  localparam int HALT_DLY_LSB = 8;
  localparam int VREG_MODE_BIT = 0;
  localparam int VREG_VSEL_BIT = 1;
  localparam int VREG_STRB_BIT = 2;
  localparam int VREG_RDY_LSB = 8;
  localparam int STAT_CPU_LSB = 0;
  localparam int STAT_VREG_LSB = 4;
  localparam int STAT_BUSY_BIT = 8;
  localparam int STAT_MEM_BIT = 9;

  // Reset values.
  localparam logic [NLEAF-1:0] LEAF_RST = 16'hffff;
  localparam logic [3:0] SW_GATE_RST = 4'hf;
  localparam logic [7:0] HALT_DLY_RST = 8'h10;
  localparam logic [7:0] HALT_DLY_MIN = 8'h06;
  localparam logic [7:0] RDY_DLY_RST = 8'h10;

  typedef enum logic [3:0] {
    CPU_ACTIVE = 4'b0001,
    CPU_WAIT = 4'b0010,
    CPU_HALTED = 4'b0100,
    CPU_EXIT = 4'b1000
  } cgp_cpu_t;

  typedef enum logic [3:0] {
    VR_OFF = 4'b0001,
    VR_NORMAL = 4'b0010,
    VR_RET_HIGH = 4'b0100,
    VR_RET_LOW = 4'b1000
  } cgp_vreg_t;

  // Regulator control outputs travel together.
  typedef struct packed {
    logic mode_line;
    logic switching_oe;
    logic linear_oe;
    logic vsel;
    logic busy;
  } cgp_vreg_out_t;

endpackage : cgp_pkg

// ### hdl/cgp_ctrl.sv
/*
  Clock gating and power state controller with an AHB-Lite register slave.
  Assumes peripheral status inputs are on CLK_I; serial input and modem pins and the
  regulator enable pin are asynchronous and synchronised here.
*/
// Implementation choices: the register addresses and the AHB-Lite interface to the registers.
// What this block does
// - Firmware stops each leaf clock independently.
// - Zero stops leaf clock, one restarts.
// - Serial sw gate zero enables autonomous gating.
// - Gate only when empty, quiet, modem stable.
// - Sync serial gates when its enable zero.
// - Halted state gates the core clock, and memory clock if enabled.
// - Memory clock gated when halted and memory enable set.
// - Programmable halt delay, minimum 6, default 16.
// - Wake or enabled interrupt restarts processor.
// - Processor only clock gated, never unpowered.
// - Halted exit takes 3 cycles, on wake or interrupt.
// - Mode select high selects linear retention.
// - State change waits strobe plus ready delay.
// - Off only while enable pin low.
module cgp_ctrl #(
  parameter int CHAR_TIME_CYC = 130208
) (
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic CE_I,
  input wire logic HSEL_I,
  input wire logic [31:0] HADDR_I,
  input wire logic [1:0] HTRANS_I,
  input wire logic HWRITE_I,
  input wire logic [2:0] HSIZE_I,
  input wire logic [31:0] HWDATA_I,
  input wire logic HREADY_I,
  output logic [31:0] HRDATA_O,
  output logic HREADYOUT_O,
  output logic HRESP_O,
  input wire logic [cgp_pkg::NASYNC-1:0] ASYNC_EMPTY_I,
  input wire logic [cgp_pkg::NASYNC-1:0] SERIAL_INPUT_LINE_I,
  input wire logic [cgp_pkg::NASYNC-1:0] SERIAL_OUTPUT_LINE_I,
  input wire logic [cgp_pkg::NASYNC-1:0] MODEM_IN_I,
  input wire logic [cgp_pkg::NSYNC-1:0] SYNC_SERIAL_ENABLE_REG_I,
  input wire logic HALT_INSTRUCTION_I,
  input wire logic WAKE_I,
  input wire logic IRQ_PEND_I,
  input wire logic REGULATOR_ENABLE_PIN_I,
  output logic [cgp_pkg::NLEAF-1:0] LEAF_CLK_O,
  output logic CORE_CLK_O,
  output logic MEM_CLK_O,
  output logic [3:0] CPU_STATE_O,
  output cgp_pkg::cgp_vreg_out_t VREG_O
);
  import cgp_pkg::*;

  logic [NLEAF-1:0] leaf_gate, next_leaf_gate;
  logic [3:0] sw_gate, next_sw_gate;
  logic cpu_halt_en, next_cpu_halt_en, mem_halt_en, next_mem_halt_en;
  logic [7:0] halt_dly, next_halt_dly, rdy_dly, next_rdy_dly;
  logic mode_sel, next_mode_sel, vsel_fld, next_vsel_fld, strobe, next_strobe;
  logic ph_write, next_ph_write;
  logic [7:0] ph_addr, next_ph_addr;
  logic [31:0] rdata, next_rdata;
  logic [NLEAF+1:0] clk_en, latched_en;
  logic [NASYNC-1:0] acg_run;
  logic [1:0] regulator_enable_pin_sync;
  cgp_cpu_t cpu_st, next_cpu_st;
  logic [7:0] cpu_cnt, next_cpu_cnt;
  cgp_vreg_t vr_st, next_vr_st, vr_tgt, next_vr_tgt;
  logic [8:0] vr_cnt, next_vr_cnt;
  logic vr_req;
  logic wake;
  logic [31:0] status;

  assign HREADYOUT_O = 1'b1;
  assign HRESP_O = 1'b0;
  assign HRDATA_O = rdata;
  assign wake = WAKE_I | IRQ_PEND_I;

  // Status word shows processor and regulator state.
  always_comb
  begin
    status = '0;
    status[STAT_CPU_LSB +: 4] = cpu_st;
    status[STAT_VREG_LSB +: 4] = vr_st;
    status[STAT_BUSY_BIT] = vr_cnt != '0;
    status[STAT_MEM_BIT] = !clk_en[NLEAF+1];
  end

  // Bus slave: read data captured in the address phase, writes in the data phase.
  always_comb
  begin
    next_leaf_gate = leaf_gate;
    next_sw_gate = sw_gate;
    next_cpu_halt_en = cpu_halt_en;
    next_mem_halt_en = mem_halt_en;
    next_halt_dly = halt_dly;
    next_rdy_dly = rdy_dly;
    next_mode_sel = mode_sel;
    next_vsel_fld = vsel_fld;
    next_strobe = 1'b0;
    next_ph_write = 1'b0;
    next_ph_addr = ph_addr;
    next_rdata = rdata;
    if (ph_write)
    begin
      case (ph_addr)
        ADDR_LEAF_GATE: next_leaf_gate = HWDATA_I[NLEAF-1:0];
        ADDR_SW_GATE: next_sw_gate = HWDATA_I[3:0];
        ADDR_HALT_CTRL:
        begin
          next_cpu_halt_en = HWDATA_I[HALT_CPU_BIT];
          next_mem_halt_en = HWDATA_I[HALT_MEM_BIT];
          next_halt_dly = (HWDATA_I[HALT_DLY_LSB +: 8] < HALT_DLY_MIN) ? HALT_DLY_MIN
                          : HWDATA_I[HALT_DLY_LSB +: 8];
        end
        ADDR_VREG_CTRL:
        begin
          next_mode_sel = HWDATA_I[VREG_MODE_BIT];
          next_vsel_fld = HWDATA_I[VREG_VSEL_BIT];
          next_strobe = HWDATA_I[VREG_STRB_BIT];
          next_rdy_dly = HWDATA_I[VREG_RDY_LSB +: 8];
        end
        default: next_strobe = 1'b0;
      endcase
    end
    if (HSEL_I && HREADY_I && HTRANS_I[1])
    begin
      next_ph_write = HWRITE_I;
      next_ph_addr = HADDR_I[7:0];
      case (HADDR_I[7:0])
        ADDR_LEAF_GATE: next_rdata = {{(32-NLEAF){1'b0}}, leaf_gate};
        ADDR_SW_GATE: next_rdata = {28'h0000000, sw_gate};
        ADDR_HALT_CTRL: next_rdata = {16'h0000, halt_dly, 6'h00, mem_halt_en, cpu_halt_en};
        ADDR_VREG_CTRL: next_rdata = {16'h0000, rdy_dly, 5'h00, 1'b0, vsel_fld, mode_sel};
        ADDR_STATUS: next_rdata = status;
        default: next_rdata = '0;
      endcase
    end
  end

  // Register file and bus phase state.
  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      leaf_gate <= LEAF_RST;
      sw_gate <= SW_GATE_RST;
      cpu_halt_en <= 1'b0;
      mem_halt_en <= 1'b0;
      halt_dly <= HALT_DLY_RST;
      rdy_dly <= RDY_DLY_RST;
      mode_sel <= 1'b0;
      vsel_fld <= 1'b0;
      strobe <= 1'b0;
      ph_write <= 1'b0;
      ph_addr <= '0;
      rdata <= '0;
    end
    else if (CE_I)
    begin
      leaf_gate <= next_leaf_gate;
      sw_gate <= next_sw_gate;
      cpu_halt_en <= next_cpu_halt_en;
      mem_halt_en <= next_mem_halt_en;
      halt_dly <= next_halt_dly;
      rdy_dly <= next_rdy_dly;
      mode_sel <= next_mode_sel;
      vsel_fld <= next_vsel_fld;
      strobe <= next_strobe;
      ph_write <= next_ph_write;
      ph_addr <= next_ph_addr;
      rdata <= next_rdata;
    end
  end

  // One autonomous gating tracker per asynchronous serial port.
  for (genvar u = 0; u < NASYNC; u++)
  begin : g_async
    logic [1:0] sin_s, mdm_s;
    logic sin_q, mdm_q, serial_output_line_q, act;
    logic [17:0] quiet, next_quiet;
    // Pin synchronisers; only the second stage is looked at.
    always_ff @(posedge CLK_I or negedge RST_N_I)
    begin
      if (!RST_N_I)
      begin
        sin_s <= 2'b11;
        mdm_s <= 2'b00;
        sin_q <= 1'b1;
        mdm_q <= 1'b0;
        serial_output_line_q <= 1'b1;
        quiet <= '0;
      end
      else if (CE_I)
      begin
        sin_s <= {sin_s[0], SERIAL_INPUT_LINE_I[u]};
        mdm_s <= {mdm_s[0], MODEM_IN_I[u]};
        sin_q <= sin_s[1];
        mdm_q <= mdm_s[1];
        serial_output_line_q <= SERIAL_OUTPUT_LINE_I[u];
        quiet <= next_quiet;
      end
    end
    assign act = (sin_q != sin_s[1]) || (mdm_q != mdm_s[1]) || (serial_output_line_q != SERIAL_OUTPUT_LINE_I[u]);
    // Quiet time restarts on any line or modem change and saturates.
    always_comb
    begin
      next_quiet = quiet;
      if (act || !ASYNC_EMPTY_I[u])
        next_quiet = '0;
      else if (quiet != 18'(CHAR_TIME_CYC))
        next_quiet = quiet + 18'd1;
    end
    assign acg_run[u] = act || !ASYNC_EMPTY_I[u] || (quiet != 18'(CHAR_TIME_CYC));
  end

  // Per-clock enables: firmware gate, plus autonomous gating for serial ports.
  always_comb
  begin
    clk_en[NLEAF-1:0] = leaf_gate;
    for (int i = 0; i < NASYNC; i++)
      clk_en[ASYNC_LEAF0+i] = leaf_gate[ASYNC_LEAF0+i] & (sw_gate[i] | acg_run[i]);
    for (int i = 0; i < NSYNC; i++)
      clk_en[SYNC_LEAF0+i] = leaf_gate[SYNC_LEAF0+i]
                             & (sw_gate[NASYNC+i] | SYNC_SERIAL_ENABLE_REG_I[i]);
    clk_en[NLEAF] = cpu_st != CPU_HALTED;
    clk_en[NLEAF+1] = !(cpu_st == CPU_HALTED && mem_halt_en);
  end

  for (genvar g = 0; g < NLEAF + 2; g++)
  begin : g_icg
    always_latch
    begin
      if (!CLK_I)
        latched_en[g] = clk_en[g];
    end
  end
  assign LEAF_CLK_O = {NLEAF{CLK_I}} & latched_en[NLEAF-1:0];
  assign CORE_CLK_O = CLK_I & latched_en[NLEAF];
  assign MEM_CLK_O = CLK_I & latched_en[NLEAF+1];
  assign CPU_STATE_O = cpu_st;

  // Processor halt sequencer; core stays powered, only clocks stop.
  always_comb
  begin
    next_cpu_st = cpu_st;
    next_cpu_cnt = cpu_cnt;
    case (cpu_st)
      CPU_ACTIVE:
        if (HALT_INSTRUCTION_I && cpu_halt_en)
        begin
          next_cpu_st = CPU_WAIT;
          next_cpu_cnt = halt_dly - 8'd1;
        end
      CPU_WAIT:
        if (wake)
          next_cpu_st = CPU_ACTIVE;
        else if (cpu_cnt == 8'd0)
          next_cpu_st = CPU_HALTED;
        else
          next_cpu_cnt = cpu_cnt - 8'd1;
      CPU_HALTED:
        if (wake)
        begin
          next_cpu_st = CPU_EXIT;
          next_cpu_cnt = 8'(EXIT_CYC - 1);
        end
      CPU_EXIT:
        if (cpu_cnt == 8'd0)
          next_cpu_st = CPU_ACTIVE;
        else
          next_cpu_cnt = cpu_cnt - 8'd1;
      default: next_cpu_st = CPU_ACTIVE;
    endcase
  end

  // Processor state registers. no power control exists here.
  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      cpu_st <= CPU_ACTIVE;
      cpu_cnt <= '0;
    end
    else if (CE_I)
    begin
      cpu_st <= next_cpu_st;
      cpu_cnt <= next_cpu_cnt;
    end
  end

  // Regulator mode sequencer with strobe interval plus ready delay.
  assign vr_req = next_mode_sel != mode_sel || strobe;
  always_comb
  begin
    next_vr_st = vr_st;
    next_vr_tgt = vr_tgt;
    next_vr_cnt = vr_cnt;
    if (vr_req)
    begin
      next_vr_tgt = !next_mode_sel ? VR_NORMAL : (vsel_fld ? VR_RET_LOW : VR_RET_HIGH);
      next_vr_cnt = 9'(STROBE_CYC) + {1'b0, next_rdy_dly};
    end
    else if (vr_cnt != '0)
      next_vr_cnt = vr_cnt - 9'd1;
    else
      next_vr_st = vr_tgt;
    if (!regulator_enable_pin_sync[1])
    begin
      next_vr_st = VR_OFF;
      next_vr_cnt = '0;
    end
    else if (vr_st == VR_OFF && vr_cnt == '0 && !vr_req)
      next_vr_st = vr_tgt;
  end

  // Regulator registers and the enable pin synchroniser.
  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      regulator_enable_pin_sync <= 2'b00;
      vr_st <= VR_OFF;
      vr_tgt <= VR_NORMAL;
      vr_cnt <= '0;
      VREG_O <= '0;
    end
    else if (CE_I)
    begin
      regulator_enable_pin_sync <= {regulator_enable_pin_sync[0], REGULATOR_ENABLE_PIN_I};
      vr_st <= next_vr_st;
      vr_tgt <= next_vr_tgt;
      vr_cnt <= next_vr_cnt;
      VREG_O.mode_line <= next_vr_st == VR_RET_HIGH || next_vr_st == VR_RET_LOW;
      VREG_O.switching_oe <= next_vr_st == VR_NORMAL;
      VREG_O.linear_oe <= next_vr_st == VR_RET_HIGH || next_vr_st == VR_RET_LOW;
      VREG_O.vsel <= next_vr_st == VR_RET_LOW;
      VREG_O.busy <= next_vr_cnt != '0;
    end
  end

  // Checks on the gating and sequencing behaviour.
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I || !CE_I);

  sequence s_halt_start;
    cpu_st == CPU_ACTIVE && HALT_INSTRUCTION_I && cpu_halt_en && !wake;
  endsequence
  sequence s_core_runs6;
    clk_en[NLEAF] [*6];
  endsequence
  property p_leaf_stop;
    (latched_en[NLEAF-1:0] & ~leaf_gate) == '0;
  endproperty
  a_leaf_stop: assert property (p_leaf_stop) else $error("Leaf clock ran while gated.");
  property p_halt_ignored;
    cpu_st == CPU_ACTIVE && !cpu_halt_en |=> cpu_st == CPU_ACTIVE;
  endproperty
  a_halt_ignored: assert property (p_halt_ignored) else $error("Halt taken while disabled.");
  property p_halt_delay;
    s_halt_start |=> s_core_runs6;
  endproperty
  a_halt_delay: assert property (p_halt_delay) else $error("Core gated too early.");
  property p_wake_exit;
    cpu_st == CPU_HALTED && wake |=> cpu_st == CPU_EXIT ##2 cpu_st == CPU_EXIT ##1
      cpu_st == CPU_ACTIVE;
  endproperty
  a_wake_exit: assert property (p_wake_exit) else $error("Halt exit latency wrong.");
  property p_mem_gate;
    cpu_st == CPU_HALTED |-> clk_en[NLEAF+1] == !mem_halt_en && !clk_en[NLEAF];
  endproperty
  a_mem_gate: assert property (p_mem_gate) else $error("Memory or core gating wrong.");
  property p_sync_gate;
    !sw_gate[NASYNC] && !SYNC_SERIAL_ENABLE_REG_I[0] |-> !clk_en[SYNC_LEAF0];
  endproperty
  a_sync_gate: assert property (p_sync_gate) else $error("Sync serial clock not gated.");
  property p_async_release;
    leaf_gate[ASYNC_LEAF0] && !ASYNC_EMPTY_I[0] |-> clk_en[ASYNC_LEAF0];
  endproperty
  a_async_release: assert property (p_async_release) else $error("Busy port clock gated.");
  property p_vreg_strobe;
    vr_req && regulator_enable_pin_sync[1] |=> VREG_O.busy [*8];
  endproperty
  a_vreg_strobe: assert property (p_vreg_strobe) else $error("Regulator change too short.");
  property p_vreg_off;
    !regulator_enable_pin_sync[1] |=> !VREG_O.switching_oe && !VREG_O.linear_oe;
  endproperty
  a_vreg_off: assert property (p_vreg_off) else $error("Regulator drives while off.");

endmodule : cgp_ctrl

// ### dv/cgp_core_model.sv
/*
  Behavioural model of the processor core facing the clock controller.
  Assumes requests from the bench arrive on the system clock edge.
*/
module cgp_core_model
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic core_clk_i,
  input wire logic halt_req_i,
  input wire logic wake_req_i,
  input wire logic irq_req_i,
  output logic halt_o,
  output logic wake_o,
  output logic irq_o,
  output int core_edges_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // halt and wake
  // Halt is a single-cycle pulse; wake and interrupt are held levels.
  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      halt_o <= 1'b0;
      wake_o <= 1'b0;
      irq_o <= 1'b0;
    end
    else
    begin
      halt_o <= halt_req_i & ~halt_o;
      wake_o <= wake_req_i;
      irq_o <= irq_req_i;
    end
  end

  // Every core clock edge stands for one executed cycle.
  always @(posedge core_clk_i) core_edges_o = core_edges_o + 1;
endmodule : cgp_core_model

// ### dv/tb_clock_gating_power_state_ctrl.sv
/*
  Self-checking bench for the clock gating and power state controller.
  Assumes an AHB-Lite slave with zero wait states and a core model partner.
*/
module tb_clock_gating_power_state_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  import cgp_pkg::*;

  localparam int RDY = 4;
  logic clk, rst_n, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans, async_empty, serial_input_line, serial_output_line, modem, sync_en;
  logic halt_req, wake_req, irq_req, halt, wake, irq, regulator_enable_pin, core_clk, mem_clk, r, ce;
  logic [15:0] leaf_clk;
  logic [3:0] cpu_state;
  cgp_vreg_out_t vreg;
  int leaf_cnt [16];
  int mem_cnt, core_edges, cyc, fail_count, n_tests, b, d, dly, ex;

  cgp_ctrl #(.CHAR_TIME_CYC(20)) DUT (
    .CLK_I(clk), .RST_N_I(rst_n), .CE_I(ce), .HSEL_I(hsel), .HADDR_I(haddr),
    .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'b010), .HWDATA_I(hwdata),
    .HREADY_I(hreadyout), .HRDATA_O(hrdata), .HREADYOUT_O(hreadyout), .HRESP_O(hresp),
    .ASYNC_EMPTY_I(async_empty), .SERIAL_INPUT_LINE_I(serial_input_line), .SERIAL_OUTPUT_LINE_I(serial_output_line),
    .MODEM_IN_I(modem), .SYNC_SERIAL_ENABLE_REG_I(sync_en), .HALT_INSTRUCTION_I(halt),
    .WAKE_I(wake), .IRQ_PEND_I(irq), .REGULATOR_ENABLE_PIN_I(regulator_enable_pin), .LEAF_CLK_O(leaf_clk),
    .CORE_CLK_O(core_clk), .MEM_CLK_O(mem_clk), .CPU_STATE_O(cpu_state), .VREG_O(vreg)
  );

  cgp_core_model core (
    .clk_i(clk), .rst_n_i(rst_n), .core_clk_i(core_clk), .halt_req_i(halt_req),
    .wake_req_i(wake_req), .irq_req_i(irq_req), .halt_o(halt), .wake_o(wake),
    .irq_o(irq), .core_edges_o(core_edges)
  );

  // Free-running system clock.
  always #4 clk = ~clk;

  // Edge counters on the gated clocks show whether each one runs.
  for (genvar g = 0; g < NLEAF; g++)
  begin : g_leaf_cnt
    always @(posedge leaf_clk[g]) leaf_cnt[g] = leaf_cnt[g] + 1;
  end
  always @(posedge mem_clk) mem_cnt = mem_cnt + 1;

  // A hung wait is cut short and counted as a mismatch.
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      fail_count++;
      end_sim();
    end
  end

  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_sim

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : wait_cyc

  task automatic wait_rdy;
    do @(posedge clk); while (hreadyout !== 1'b1);
  endtask : wait_rdy

  // One single word transfer: address phase, then data phase.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= wr;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask : bus

  // Index 16 is the memory clock, 17 the core clock.
  function automatic int cnt_of(input int k);
    return k < 16 ? leaf_cnt[k] : (k == 16 ? mem_cnt : core_edges);
  endfunction : cnt_of

  // Counts are taken on falling edges, so they never race a gated rising edge.
  task automatic runs(input int k);
    int c;
    @(negedge clk);
    c = cnt_of(k);
    repeat (10) @(negedge clk);
    r = (cnt_of(k) != c);
    @(posedge clk);
  endtask : runs

  task automatic halt_pulse;
    halt_req <= 1'b1;
    @(posedge clk);
    halt_req <= 1'b0;
  endtask : halt_pulse

  initial
  begin
    clk = 0; rst_n = 0; hsel = 0; haddr = 0; htrans = 0; hwrite = 0; hwdata = 0;
    async_empty = 2'b11; serial_input_line = 2'b11; serial_output_line = 2'b11; modem = 0; sync_en = 2'b11;
    halt_req = 0; wake_req = 0; irq_req = 0; regulator_enable_pin = 1; ce = 1;
    wait_cyc(4);
    rst_n <= 1'b1;
    wait_cyc(6);
    // Reset values and an unmapped word.
    bus(0, ADDR_LEAF_GATE, 0); check("leaf_rst", rd, {16'h0, LEAF_RST});
    bus(0, ADDR_SW_GATE, 0); check("sw_rst", rd, {28'h0, SW_GATE_RST});
    bus(0, ADDR_HALT_CTRL, 0); check("dly_rst", rd[15:8], HALT_DLY_RST);
    bus(0, ADDR_VREG_CTRL, 0); check("rdy_rst", rd[15:8], RDY_DLY_RST);
    bus(0, ADDR_STATUS, 0); check("stat_rst", rd[9:0], {2'b0, VR_NORMAL, CPU_ACTIVE});
    bus(1, 8'h14, 32'hffffffff);
    bus(0, 8'h14, 0); check("unmapped", rd, 0);
    check("hresp", hresp, 0);
    // A write while the clock enable is low must not land.
    ce <= 1'b0;
    bus(1, ADDR_LEAF_GATE, 0);
    ce <= 1'b1;
    bus(0, ADDR_LEAF_GATE, 0); check("ce_hold", rd, {16'h0, LEAF_RST});
    // Leaves 4, 9 and 14 each stop alone; leaf 14 restarts on a one.
    for (int k = 4; k < 16; k += 5)
    begin
      bus(1, ADDR_LEAF_GATE, {16'h0, LEAF_RST ^ (16'h1 << k)});
      runs(k); check("leaf_off", r, 0);
      runs(k ^ 1); check("leaf_other", r, 1);
    end
    bus(1, ADDR_LEAF_GATE, {16'h0, LEAF_RST});
    runs(14); check("leaf_back", r, 1);
    // Synchronous port gates once its enable register reads zero.
    bus(1, ADDR_SW_GATE, 32'h3);
    sync_en <= 2'b10;
    wait_cyc(2);
    runs(2); check("sync_off", r, 0);
    runs(3); check("sync_on", r, 1);
    sync_en <= 2'b11;
    runs(2); check("sync_back", r, 1);
    // Asynchronous ports gate only when idle and quiet.
    bus(1, ADDR_SW_GATE, 32'hc);
    wait_cyc(40);
    runs(0); check("async_idle", r, 0);
    serial_input_line[0] <= 1'b0;
    runs(0); check("async_line", r, 1);
    wait_cyc(40);
    async_empty[0] <= 1'b0;
    runs(0); check("async_data", r, 1);
    async_empty[0] <= 1'b1;
    wait_cyc(40);
    runs(1); check("async1_idle", r, 0);
    modem[1] <= 1'b1;
    runs(1); check("async1_modem", r, 1);
    bus(1, ADDR_SW_GATE, 32'hf);
    wait_cyc(40);
    runs(1); check("async_sw_on", r, 1);
    // Halt without the enable bit leaves the core running.
    bus(1, ADDR_HALT_CTRL, 32'h0600);
    halt_pulse();
    wait_cyc(30);
    check("halt_off", cpu_state, CPU_ACTIVE);
    // Halt with clamped and plain delays, memory gated or not.
    for (int i = 0; i < 2; i++)
    begin
      dly = i ? 8 : 2;
      ex = dly < HALT_DLY_MIN ? HALT_DLY_MIN : dly;
      bus(1, ADDR_HALT_CTRL, {16'h0, dly[7:0], 6'h0, i == 0, 1'b1});
      bus(0, ADDR_HALT_CTRL, 0); check("dly", rd[15:8], ex);
      b = core_edges;
      halt_pulse();
      wait_cyc(30);
      d = core_edges - b;
      check("entry", d >= ex && d <= ex + 4, 1);
      check("halted", cpu_state, CPU_HALTED);
      runs(17); check("core_off", r, 0);
      runs(16); check("mem_clk", r, i);
      bus(0, ADDR_STATUS, 0); check("mem_flag", rd[9], i == 0);
      if (i == 0)
        irq_req <= 1'b1;
      else
        wake_req <= 1'b1;
      wait_cyc(8);
      check("woken", cpu_state, CPU_ACTIVE);
      runs(17); check("core_on", r, 1);
      irq_req <= 1'b0;
      wake_req <= 1'b0;
    end
    // Retention entry waits strobe interval plus ready delay.
    // bench stands for firmware already on slow clock.
    bus(1, ADDR_VREG_CTRL, {16'h0, RDY[7:0], 8'h01});
    wait_cyc(STROBE_CYC + RDY - 1);
    check("busy", vreg.busy, 1);
    wait_cyc(2);
    check("done", vreg.busy, 0);
    bus(0, ADDR_STATUS, 0); check("ret_hi", rd[7:4], VR_RET_HIGH);
    check("ret_oe", {vreg.mode_line, vreg.switching_oe, vreg.linear_oe}, 3'b101);
    bus(1, ADDR_VREG_CTRL, {16'h0, RDY[7:0], 8'h03});
    bus(1, ADDR_VREG_CTRL, {16'h0, RDY[7:0], 8'h07});
    wait_cyc(STROBE_CYC + RDY + 10);
    bus(0, ADDR_STATUS, 0); check("ret_lo", rd[7:4], VR_RET_LOW);
    check("vsel", vreg.vsel, 1);
    bus(1, ADDR_VREG_CTRL, {16'h0, RDY[7:0], 8'h00});
    wait_cyc(STROBE_CYC + RDY + 10);
    bus(0, ADDR_STATUS, 0); check("normal", rd[7:4], VR_NORMAL);
    check("nrm_oe", {vreg.mode_line, vreg.switching_oe, vreg.linear_oe}, 3'b010);
    regulator_enable_pin <= 1'b0;
    wait_cyc(6);
    bus(0, ADDR_STATUS, 0); check("off", rd[7:4], VR_OFF);
    check("off_oe", {vreg.switching_oe, vreg.linear_oe}, 2'b00);
    regulator_enable_pin <= 1'b1;
    wait_cyc(STROBE_CYC + RDY + 10);
    bus(0, ADDR_STATUS, 0); check("on_again", rd[7:4], VR_NORMAL);
    end_sim();
  end
endmodule : tb_clock_gating_power_state_ctrl
